// ===== rtl/tpb_ctrl.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
// Operation
// - Two phases start their cycles half a period apart.
// - Phase clock sets high-side gate; peak-current comparator clears it.
// - Low-side stays on after high-side until reverse current or next cycle.
// - In dropout force high-side off about 500 ns every sixth cycle.
// - Switching disabled while run control is low.
// - Enable at soft-start threshold with command clamped to 30 percent.
// - Power-save select high: low-side held until next cycle.
// - Power-save select low: low-side off on reverse current.
// - Power-save low with deeper sleep request: phase two off.
// - During start-up use boot setpoint, ignore voltage code.
// - Keep ignoring code 15 cycles after regulation and host power good.
// - Deeper sleep ignores code and sleep request; uses parallel resistor point.
// - Sleep request low applies programmed offset below code setpoint.
// - Overvoltage forces high-side off and low-side on until cleared; low-side is forced on only while the phase is enabled.
// - Power-good pulled low outside plus-minus 10 percent window.
// - Without host power good, window is against boot setpoint.
// - Code or sleep request change masks power-good low for 110 us.
// - Another change during masking restarts the mask timer.
// - After soft-start, undervoltage runs timeout then latches off until run cycles.
// - Foldback limiting active whenever output below 70 percent.
// - Code delay starts only on host power good rising edge.
// - Deeper sleep entered while request high, left when low.
module tpb_ctrl
   import tpb_pkg::*;
#(
   parameter int PG_MASK_CYCLES = PG_MASK_CYC,
   parameter int SC_TIMEOUT_CYCLES = DEF_SC_TIMEOUT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic i_ss_enable,
   input wire logic i_ss_done,
   input wire logic [1:0] i_peak_current_cmp,
   input wire logic [1:0] i_reverse_current_cmp,
   input wire logic i_overvoltage_cmp,
   input wire logic i_output_in_window,
   input wire logic i_undervoltage_cmp,
   input wire logic i_power_save_select_n,
   input wire logic i_deeper_sleep_request,
   input wire logic i_deep_sleep_request_n,
   input wire logic i_host_power_good_in,
   input wire logic [5:0] i_voltage_code,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_high_side_gate_a,
   output logic o_low_side_gate_a,
   output logic o_high_side_gate_b,
   output logic o_low_side_gate_b,
   output logic o_output_in_window_oe,
   output logic o_output_in_window_out,
   output logic [3:0] o_setpoint_select,
   output logic [5:0] o_voltage_code,
   output logic o_sleep_offset_en,
   output logic o_current_clamp_en,
   output logic o_foldback_en
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int NS = 14;
   logic [NS-1:0] s1_ff;
   logic [NS-1:0] s2_ff;
   wire [NS-1:0] raw = {i_run, i_ss_enable, i_ss_done, i_peak_current_cmp,
      i_reverse_current_cmp, i_overvoltage_cmp, i_output_in_window,
      i_undervoltage_cmp, i_power_save_select_n, i_deeper_sleep_request,
      i_deep_sleep_request_n, i_host_power_good_in};
   logic [5:0] code1_ff;
   logic [5:0] code2_ff;
   logic [5:0] code3_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         // Sleep request idles high, so no false change follows reset
         s1_ff <= 14'h0002;
         s2_ff <= 14'h0002;
         code1_ff <= 6'h00;
         code2_ff <= 6'h00;
         code3_ff <= 6'h00;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         code1_ff <= i_voltage_code;
         code2_ff <= code1_ff;
         code3_ff <= code2_ff;
      end
   end
   wire run_s = s2_ff[13];
   wire ss_en_s = s2_ff[12];
   wire ss_done_s = s2_ff[11];
   wire [1:0] peak_s = s2_ff[10:9];
   wire [1:0] rev_s = s2_ff[8:7];
   wire ov_s = s2_ff[6];
   wire win_s = s2_ff[5];
   wire uv_s = s2_ff[4];
   wire psel_s = s2_ff[3];
   wire deeper_s = s2_ff[2];
   wire sleep_n_s = s2_ff[1];
   wire hpg_s = s2_ff[0];
   // ----------------------------------------
   // Register port
   // ----------------------------------------
   logic [15:0] period_ff;
   logic [31:0] rdata_ff;
   logic [31:0] status_w;
   wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
   // ----------------------------------------
   // Run state and short-circuit latch-off
   // ----------------------------------------
   tpb_run_t run_ff;
   tpb_run_t nxt_run;
   logic [31:0] sc_cnt_ff;
   wire sc_expired = (sc_cnt_ff >= 32'(SC_TIMEOUT_CYCLES));
   always_comb begin
      nxt_run = run_ff;
      unique case (run_ff)
         RUN_OFF: begin
            if (run_s && ss_en_s) begin
               nxt_run = RUN_ON;
            end
         end
         RUN_ON: begin
            if (!run_s) begin
               nxt_run = RUN_OFF;
            end else if (sc_expired) begin
               nxt_run = RUN_LATCHED;
            end
         end
         RUN_LATCHED: begin
            if (!run_s) begin
               nxt_run = RUN_OFF;
            end
         end
         default: nxt_run = RUN_OFF;
      endcase
   end
   wire enable = (run_ff == RUN_ON);
   wire sc_arm = enable && ss_done_s && uv_s;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         run_ff <= RUN_OFF;
         sc_cnt_ff <= 32'h0;
      end else begin
         run_ff <= nxt_run;
         sc_cnt_ff <= sc_arm ? sc_cnt_ff + 32'h1 : 32'h0;
      end
   end
   assign o_current_clamp_en = enable && !ss_done_s;
   assign o_foldback_en = uv_s;
   // ----------------------------------------
   // Antiphase oscillator and dropout refresh
   // ----------------------------------------
   logic [15:0] osc_ff;
   logic [2:0] cyc6_ff;
   logic [15:0] refresh_ff;
   logic [1:0] held_ff;
   wire [15:0] half = {1'b0, period_ff[15:1]};
   wire tick_a = (osc_ff == 16'h0);
   wire tick_b = (osc_ff == half);
   wire [1:0] hs_held;
   wire dropout = held_ff[0] && hs_held[0];
   wire refresh_go = tick_a && dropout && (cyc6_ff == 3'(REFRESH_EVERY - 1));
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         osc_ff <= 16'h0;
         cyc6_ff <= 3'h0;
         refresh_ff <= 16'h0;
         held_ff <= 2'h0;
      end else begin
         osc_ff <= (osc_ff >= period_ff - 16'h1) ? 16'h0 : osc_ff + 16'h1;
         if (tick_a) begin
            held_ff <= hs_held;
            cyc6_ff <= (cyc6_ff == 3'(REFRESH_EVERY - 1)) ? 3'h0 : cyc6_ff + 3'h1;
         end
         if (refresh_go) begin
            refresh_ff <= 16'(REFRESH_OFF_CYC);
         end else if (refresh_ff != 16'h0) begin
            refresh_ff <= refresh_ff - 16'h1;
         end
      end
   end
   // ----------------------------------------
   // Phases
   // ----------------------------------------
   tpb_phase_if ph_if[2] ();
   wire shed_b = !psel_s && deeper_s;
   wire [1:0] ticks = {tick_b, tick_a};
   for (genvar g = 0; g < 2; g++) begin : g_ph
      assign ph_if[g].start = ticks[g];
      assign ph_if[g].enable = enable && !(g == 1 && shed_b);
      assign ph_if[g].sync_mode = psel_s;
      assign ph_if[g].refresh_off = (refresh_ff != 16'h0);
      assign ph_if[g].ov = ov_s;
      assign ph_if[g].peak = peak_s[g];
      assign ph_if[g].reverse = rev_s[g];
      assign hs_held[g] = ph_if[g].hs_held;
      tpb_phase u_ph (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .p(ph_if[g])
      );
   end
   assign o_high_side_gate_a = ph_if[0].hs;
   assign o_low_side_gate_a = ph_if[0].ls;
   assign o_high_side_gate_b = ph_if[1].hs;
   assign o_low_side_gate_b = ph_if[1].ls;
   // ----------------------------------------
   // Setpoint source
   // ----------------------------------------
   logic hpg_d_ff;
   logic [3:0] code_cnt_ff;
   logic code_ok_ff;
   logic dly_arm_ff;
   wire hpg_rise = hpg_s && !hpg_d_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hpg_d_ff <= 1'b0;
         code_cnt_ff <= 4'h0;
         code_ok_ff <= 1'b0;
         dly_arm_ff <= 1'b0;
      end else begin
         hpg_d_ff <= hpg_s;
         if (!enable || !hpg_s) begin
            code_ok_ff <= 1'b0;
            dly_arm_ff <= 1'b0;
            code_cnt_ff <= 4'h0;
         end else if (hpg_rise) begin
            dly_arm_ff <= 1'b1;
            code_cnt_ff <= 4'h0;
         end else if (dly_arm_ff && !code_ok_ff && ss_done_s && win_s && tick_a) begin
            if (code_cnt_ff == 4'(CODE_DELAY_CYCLES - 1)) begin
               code_ok_ff <= 1'b1;
            end
            code_cnt_ff <= code_cnt_ff + 4'h1;
         end
      end
   end
   tpb_src_t src_w;
   assign src_w = deeper_s ? SRC_DEEPER :
      !code_ok_ff || !hpg_s ? SRC_BOOT :
      !sleep_n_s ? SRC_SLEEP : SRC_CODE;
   logic [3:0] src_ff;
   logic [5:0] code_out_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         src_ff <= SRC_BOOT;
         code_out_ff <= 6'h00;
      end else begin
         src_ff <= src_w;
         // Take the code only once two samples agree
         if (code3_ff == code2_ff) begin
            code_out_ff <= code3_ff;
         end
      end
   end
   assign o_setpoint_select = src_ff;
   assign o_voltage_code = code_out_ff;
   assign o_sleep_offset_en = (src_ff == SRC_SLEEP);
   // ----------------------------------------
   // Power-good with masking timer
   // ----------------------------------------
   logic sleep_d_ff;
   logic deeper_d_ff;
   logic [31:0] mask_cnt_ff;
   logic pg_low_ff;
   wire mode_change = (code3_ff != code2_ff) || (sleep_d_ff != sleep_n_s) ||
      (deeper_d_ff != deeper_s);
   wire masked = (mask_cnt_ff != 32'h0);
   // Boot-source window when host power good is low is handled by setpoint select
   wire pg_bad = !win_s || !enable;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sleep_d_ff <= 1'b1;
         deeper_d_ff <= 1'b0;
         mask_cnt_ff <= 32'h0;
         pg_low_ff <= 1'b1;
      end else begin
         sleep_d_ff <= sleep_n_s;
         deeper_d_ff <= deeper_s;
         if (mode_change) begin
            mask_cnt_ff <= 32'(PG_MASK_CYCLES);
         end else if (masked) begin
            mask_cnt_ff <= mask_cnt_ff - 32'h1;
         end
         if (mode_change || masked) begin
            pg_low_ff <= pg_low_ff && pg_bad;
         end else begin
            pg_low_ff <= pg_bad;
         end
      end
   end
   assign o_output_in_window_oe = pg_low_ff;
   assign o_output_in_window_out = 1'b0;
   // ----------------------------------------
   // Register access
   // ----------------------------------------
   always_comb begin
      status_w = 32'h0;
      status_w[ST_SRC_LSB +: 4] = src_ff;
      status_w[ST_PG_BIT] = !pg_low_ff;
      status_w[ST_MASK_BIT] = masked;
      status_w[ST_LATCH_BIT] = (run_ff == RUN_LATCHED);
      status_w[ST_FOLD_BIT] = uv_s;
      status_w[ST_RUN_BIT] = enable;
      status_w[ST_SHED_BIT] = shed_b;
   end
   wire [31:0] rsel = (i_addr == ADDR_CTRL) ? {16'h0, period_ff} :
      (i_addr == ADDR_STATUS) ? status_w :
      (i_addr == ADDR_CODE) ? {26'h0, code_out_ff} : 32'h0;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         period_ff <= CTRL_RST;
         rdata_ff <= 32'h0;
      end else begin
         if (wr_ctrl && i_wdata[CTRL_PERIOD_LSB +: 16] >= 16'h4) begin
            period_ff <= i_wdata[CTRL_PERIOD_LSB +: 16];
         end
         rdata_ff <= i_rd ? rsel : 32'h0;
      end
   end
   assign o_rdata = rdata_ff;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_ov;
      ov_s;
   endsequence
   chk_ov_response: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_ov ##1 ov_s |-> !o_high_side_gate_a && !o_high_side_gate_b)
      else $error("high side on in overvoltage");
   chk_run_low_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !run_s ##1 !run_s |=> !o_high_side_gate_a && !o_high_side_gate_b)
      else $error("switching while run low");
   chk_shed_phase_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      shed_b ##1 shed_b |-> !o_high_side_gate_b)
      else $error("phase two on while shed");
   chk_antiphase: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(tick_a && tick_b))
      else $error("phases started together");
   chk_mask_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      mode_change |=> mask_cnt_ff == 32'(PG_MASK_CYCLES))
      else $error("mask timer not restarted");
   chk_mask_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      masked && !pg_low_ff |=> !pg_low_ff)
      else $error("power good fell while masked");
   chk_deeper_src: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      deeper_s |=> o_setpoint_select == SRC_DEEPER)
      else $error("deeper sleep source wrong");
   chk_boot_src: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !hpg_s |=> o_setpoint_select != SRC_CODE)
      else $error("code used before host power good");
   chk_refresh_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      refresh_go |=> (refresh_ff == 16'(REFRESH_OFF_CYC)))
      else $error("refresh off time wrong");
endmodule // tpb_ctrl

// ===== pkg/tpb_pkg.sv
package tpb_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int REFRESH_OFF_NS = 500;
   localparam int REFRESH_OFF_CYC = (REFRESH_OFF_NS * CLK_MHZ) / 1000;
   localparam int PG_MASK_US = 110;
   localparam int PG_MASK_CYC = PG_MASK_US * CLK_MHZ;
   localparam int REFRESH_EVERY = 6;
   localparam int CODE_DELAY_CYCLES = 15;
   localparam int SS_ENABLE_MV = 1500;
   localparam int SS_CLAMP_PCT = 30;
   localparam int DEF_PERIOD_CYC = 500;
   localparam int DEF_SC_TIMEOUT_CYC = 250000;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CODE = 4'h8;
   localparam int CTRL_PERIOD_LSB = 0;
   localparam logic [15:0] CTRL_RST = 16'h01f4;
   localparam int ST_SRC_LSB = 0;
   localparam int ST_PG_BIT = 4;
   localparam int ST_MASK_BIT = 5;
   localparam int ST_LATCH_BIT = 6;
   localparam int ST_FOLD_BIT = 7;
   localparam int ST_RUN_BIT = 8;
   localparam int ST_SHED_BIT = 9;
   // ----------------------------------------
   // Setpoint source selection and run state
   // ----------------------------------------
   typedef enum logic [3:0] {
      SRC_BOOT = 4'h1,
      SRC_CODE = 4'h2,
      SRC_SLEEP = 4'h4,
      SRC_DEEPER = 4'h8
   } tpb_src_t;
   typedef enum logic [2:0] {
      RUN_OFF = 3'h1,
      RUN_ON = 3'h2,
      RUN_LATCHED = 3'h4
   } tpb_run_t;
endpackage

// ===== pkg/tpb_phase_if.sv
`timescale 1ns/10ps
interface tpb_phase_if;
   logic start;
   logic enable;
   logic sync_mode;
   logic refresh_off;
   logic ov;
   logic peak;
   logic reverse;
   logic hs;
   logic ls;
   logic hs_held;
   modport ctl (output start, enable, sync_mode, refresh_off, ov, peak, reverse,
      input hs, ls, hs_held);
   modport ph (input start, enable, sync_mode, refresh_off, ov, peak, reverse,
      output hs, ls, hs_held);
endinterface

// ===== rtl/tpb_phase.sv
`timescale 1ns/10ps
module tpb_phase
   import tpb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   tpb_phase_if.ph p
);
   logic latch_ff;
   logic hs_ff;
   logic ls_ff;
   logic nxt_latch;
   logic nxt_hs;
   logic nxt_ls;
   wire set_latch = p.enable && p.start && !p.ov;
   wire rst_latch = !p.enable || p.peak || p.ov;
   wire ls_end = p.start || (!p.sync_mode && p.reverse);
   // ----------------------------------------
   // Set/reset latch and low-side control
   // ----------------------------------------
   always_comb begin
      nxt_latch = latch_ff;
      nxt_ls = ls_ff;
      if (rst_latch) begin
         nxt_latch = 1'b0;
      end else if (set_latch) begin
         nxt_latch = 1'b1;
      end
      // Refresh masks the gate but keeps the latch, so the gate resumes after it
      nxt_hs = nxt_latch && !p.refresh_off;
      if (!p.enable) begin
         nxt_ls = 1'b0;
      end else if (p.ov) begin
         nxt_ls = 1'b1;
      end else if (nxt_hs) begin
         nxt_ls = 1'b0;
      end else if (hs_ff) begin
         nxt_ls = 1'b1;
      end else if (ls_end) begin
         nxt_ls = 1'b0;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         latch_ff <= 1'b0;
         hs_ff <= 1'b0;
         ls_ff <= 1'b0;
      end else begin
         latch_ff <= nxt_latch;
         hs_ff <= nxt_hs;
         ls_ff <= nxt_ls;
      end
   end
   assign p.hs = hs_ff;
   assign p.ls = ls_ff;
   assign p.hs_held = hs_ff && p.start;

   chk_gates_exclusive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(hs_ff && ls_ff)) else $error("both gates on");
endmodule // tpb_phase

// ===== test/tpb_stage_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Power stage and current comparator model
// ----------------------------------------
module tpb_stage_model #(
   parameter int ON_CYC = 8,
   parameter int REV_CYC = 12
) (
   input wire logic i_clk,
   input wire logic [1:0] i_hs,
   input wire logic [1:0] i_ls,
   input wire logic i_stuck,
   output logic [1:0] o_peak,
   output logic [1:0] o_reverse
);
   int hs_cnt [2];
   int ls_cnt [2];
   initial begin
      o_peak = 2'h0;
      o_reverse = 2'h0;
      hs_cnt = '{0, 0};
      ls_cnt = '{0, 0};
   end
   // Peak trips after a fixed on-time unless held off (dropout); reverse after a fixed off-time
   always @(posedge i_clk) begin
      for (int k = 0; k < 2; k++) begin
         hs_cnt[k] <= i_hs[k] ? hs_cnt[k] + 1 : 0;
         ls_cnt[k] <= i_ls[k] ? ls_cnt[k] + 1 : 0;
         o_peak[k] <= i_hs[k] && !i_stuck && (hs_cnt[k] >= ON_CYC);
         o_reverse[k] <= i_ls[k] && (ls_cnt[k] >= REV_CYC);
      end
   end
endmodule // tpb_stage_model

// ===== test/two_phase_buck_control_logic_bench.sv
`timescale 1ns/10ps
module two_phase_buck_control_logic_bench;
   import tpb_pkg::*;
   localparam int PER = 40;
   localparam int MASK = 50;
   localparam int SCT = 100;
   localparam int LIM = 20000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0, ss_en = 1'b0, ss_done = 1'b0, ov = 1'b0, win = 1'b1, uv = 1'b0;
   logic ps_n = 1'b1, deeper = 1'b0, deep_n = 1'b1, host_pg = 1'b0, stuck = 1'b0;
   logic [5:0] code = 6'h15;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0;
   logic [31:0] rdata, d;
   logic [1:0] peak, rev;
   logic hs_a, ls_a, hs_b, ls_b, oe, pg_out, sp_en, clamp, fold, ok;
   logic [3:0] sel, gates;
   logic [5:0] code_o;
   int cyc_cnt = 0, error_cnt = 0, tests_run = 0, t0, t1, t2;
   assign gates = {ls_b, hs_b, ls_a, hs_a};
   always #2 clk = ~clk;
   tpb_ctrl #(.PG_MASK_CYCLES(MASK), .SC_TIMEOUT_CYCLES(SCT)) tpb_ctrl_inst (
      .i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_ss_enable(ss_en), .i_ss_done(ss_done),
      .i_peak_current_cmp(peak), .i_reverse_current_cmp(rev), .i_overvoltage_cmp(ov),
      .i_output_in_window(win), .i_undervoltage_cmp(uv), .i_power_save_select_n(ps_n),
      .i_deeper_sleep_request(deeper), .i_deep_sleep_request_n(deep_n),
      .i_host_power_good_in(host_pg), .i_voltage_code(code), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_high_side_gate_a(hs_a), .o_low_side_gate_a(ls_a), .o_high_side_gate_b(hs_b),
      .o_low_side_gate_b(ls_b), .o_output_in_window_oe(oe), .o_output_in_window_out(pg_out),
      .o_setpoint_select(sel), .o_voltage_code(code_o), .o_sleep_offset_en(sp_en),
      .o_current_clamp_en(clamp), .o_foldback_en(fold));
   tpb_stage_model tpb_stage_model_inst (.i_clk(clk), .i_hs({hs_b, hs_a}),
      .i_ls({ls_b, ls_a}), .i_stuck(stuck), .o_peak(peak), .o_reverse(rev));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      tests_run++;
      if (act !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic check_bit(input logic act, input logic exp);
      check({31'h0, act}, {31'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_lvl(input int idx, input logic lvl, input int lim, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         cyc(1);
         hit = (gates[idx] === lvl);
      end
   endtask
   task automatic rise_at(input int idx, output int t);
      wait_lvl(idx, 1'b0, 1500, ok);
      wait_lvl(idx, 1'b1, 1500, ok);
      check_bit(ok, 1'b1);
      t = cyc_cnt;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic ls_len(output int n);
      rise_at(1, t0);
      wait_lvl(1, 1'b0, PER, ok);
      n = cyc_cnt - t0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_regs();
      check({28'h0, gates}, 32'h0);
      check_bit(oe, 1'b1);
      check({28'h0, sel}, 32'h1);
      reg_rd(ADDR_CTRL, d);
      check(d, {16'h0, CTRL_RST});
      reg_wr(ADDR_CTRL, PER);
      reg_wr(ADDR_CTRL, 32'h3);
      reg_rd(ADDR_CTRL, d);
      check(d, PER);
      reg_rd(4'hc, d);
      check(d, 32'h0);
   endtask
   task automatic t_softstart();
      @(posedge clk);
      run <= 1'b1;
      cyc(100);
      check({28'h0, gates}, 32'h0);
      @(posedge clk);
      ss_en <= 1'b1;
      cyc(5);
      check_bit(clamp, 1'b1);
      rise_at(0, t0);
      @(posedge clk);
      ss_done <= 1'b1;
      cyc(5);
      check_bit(clamp, 1'b0);
   endtask
   task automatic t_phases();
      rise_at(0, t0);
      rise_at(2, t1);
      rise_at(0, t2);
      check(t1 - t0, PER / 2);
      check(t2 - t0, PER);
      ls_len(t1);
      check_bit(t1 > 20, 1'b1);
      @(posedge clk);
      ps_n <= 1'b0;
      cyc(PER);
      ls_len(t1);
      check_bit(t1 < 20, 1'b1);
   endtask
   task automatic t_setpoint();
      @(posedge clk);
      host_pg <= 1'b1;
      cyc(12 * PER);
      check({28'h0, sel}, 32'h1);
      cyc(6 * PER);
      check({28'h0, sel}, 32'h2);
      check({26'h0, code_o}, 32'h15);
      @(posedge clk);
      deep_n <= 1'b0;
      cyc(6);
      check({28'h0, sel}, 32'h4);
      check_bit(sp_en, 1'b1);
      @(posedge clk);
      deeper <= 1'b1;
      cyc(6);
      check({28'h0, sel}, 32'h8);
      wait_lvl(2, 1'b1, 2 * PER, ok);
      check_bit(ok, 1'b0);
      reg_rd(ADDR_STATUS, d);
      check_bit(d[ST_SHED_BIT], 1'b1);
      @(posedge clk);
      deeper <= 1'b0;
      deep_n <= 1'b1;
      ps_n <= 1'b1;
      cyc(6);
      check({28'h0, sel}, 32'h2);
      @(posedge clk);
      host_pg <= 1'b0;
      cyc(6);
      check({28'h0, sel}, 32'h1);
   endtask
   task automatic t_mask();
      cyc(MASK + 50);
      check_bit(oe, 1'b0);
      check_bit(pg_out, 1'b0);
      @(posedge clk);
      code <= 6'h16;
      win <= 1'b0;
      cyc(40);
      check_bit(oe, 1'b0);
      @(posedge clk);
      code <= 6'h17;
      cyc(40);
      check_bit(oe, 1'b0);
      cyc(40);
      check_bit(oe, 1'b1);
      @(posedge clk);
      win <= 1'b1;
      cyc(10);
      check_bit(oe, 1'b0);
   endtask
   task automatic t_ov();
      @(posedge clk);
      ov <= 1'b1;
      cyc(5);
      check({28'h0, gates}, 32'ha);
      cyc(PER);
      check({28'h0, gates}, 32'ha);
      @(posedge clk);
      ov <= 1'b0;
      rise_at(0, t0);
   endtask
   task automatic t_dropout();
      reg_wr(ADDR_CTRL, 32'd200);
      @(posedge clk);
      stuck <= 1'b1;
      cyc(400);
      wait_lvl(0, 1'b1, 1500, ok);
      wait_lvl(0, 1'b0, 1500, ok);
      t0 = cyc_cnt;
      wait_lvl(0, 1'b1, 1500, ok);
      check(cyc_cnt - t0, REFRESH_OFF_CYC);
      @(posedge clk);
      stuck <= 1'b0;
      reg_wr(ADDR_CTRL, PER);
   endtask
   task automatic t_short();
      @(posedge clk);
      uv <= 1'b1;
      cyc(5);
      check_bit(fold, 1'b1);
      reg_rd(ADDR_STATUS, d);
      check_bit(d[ST_LATCH_BIT], 1'b0);
      cyc(SCT + 10);
      reg_rd(ADDR_STATUS, d);
      check_bit(d[ST_LATCH_BIT], 1'b1);
      @(posedge clk);
      uv <= 1'b0;
      cyc(PER);
      check({28'h0, gates}, 32'h0);
      check_bit(fold, 1'b0);
      @(posedge clk);
      run <= 1'b0;
      cyc(10);
      check({28'h0, gates}, 32'h0);
      @(posedge clk);
      run <= 1'b1;
      cyc(10);
      reg_rd(ADDR_STATUS, d);
      check_bit(d[ST_LATCH_BIT], 1'b0);
   endtask
   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIM) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      t_reset_regs();
      t_softstart();
      t_phases();
      t_setpoint();
      t_mask();
      t_ov();
      t_dropout();
      t_short();
      wrap_up();
   end
endmodule // two_phase_buck_control_logic_bench
